// ### hw/rs485_exp_pkg.sv
// shared constants, types and crc for the rs485 expander bus
package rs485_exp_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD = 1_000_000;
    localparam int BIT_CYC = CLK_HZ / BAUD;
    localparam int TURN_CYC = 2 * BIT_CYC;
    localparam int ADDR_W = 4;
    localparam int NODES = 16;
    localparam int FIELD_W = 4;
    localparam int PAY_W = 32;
    localparam int CRC_W = 8;
    localparam int BODY_W = ADDR_W + FIELD_W + PAY_W;
    localparam int FRAME_W = BODY_W + CRC_W;
    localparam int BITCNT_W = 6;
    localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
    localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;
    localparam int CH_OUT = 8;
    localparam int DAC_CH = 4;
    localparam int DAC_W = 6;
    localparam int ADC_CH = 8;
    localparam int ADC_W = 4;
    localparam int DAC_EN_POS = DAC_CH * DAC_W;
    localparam int INV_POS = 8;
    localparam int LINK_TIMEOUT_US = 10_000;
    localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1_000);
    localparam int SLOT_US = 150;
    localparam int SLOT_CYC = SLOT_US * (CLK_HZ / 1_000_000);
    localparam int MISS_LIMIT = 3;
    localparam int CNT_W = 24;

    typedef enum logic [3:0] {
        CMD_IDENT = 4'h1,
        CMD_DATA = 4'h2
    } cmd_t;

    typedef enum logic [3:0] {
        KIND_RELAY = 4'h1,
        KIND_INPUT = 4'h2,
        KIND_ANALOG = 4'h3
    } node_kind_t;

    function automatic logic [CRC_W-1:0] crc_calc(input logic [BODY_W-1:0] d);
        logic [CRC_W-1:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = BODY_W - 1; i >= 0; i--) begin
            fb = c[CRC_W-1] ^ d[i];
            c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction
endpackage

// ### hw/rs485_exp_if.sv
// half-duplex rs485 line between bus host and expander nodes
`timescale 1ns/1ns
interface rs485_exp_if;
    logic host_tx;
    logic host_oe;
    logic node_tx;
    logic node_oe;
    logic line;

    // idle line rests high
    assign line = host_oe ? host_tx : (node_oe ? node_tx : 1'b1);

    modport host (output host_tx, output host_oe, input line);
    modport node (output node_tx, output node_oe, input line);
endinterface

// ### hw/rs485_exp_node.sv
// rs485 expander node: relay, input or analogue kind
`timescale 1ns/1ns
// What this block does
// - host finds every node by itself
// - host drops nodes that stop answering
// - link timeout drives outputs safe, lamp blinks
// - 4-bit switch address, answer only that
// - lamp blinks unidentified or dropped
// - lamp dark during identification
// - lamp lit while exchanging data
// - host lamp blinks while initialising nodes
// - host lamp lit when all nodes exchange
// - host lamp dark after any drop
// - eight relays, each with own inversion
// - eight inputs, level and complement reported
// - four dac outputs, eight adc inputs
// - disabled dac channel forced to zero
module rs485_exp_node #(
    parameter rs485_exp_pkg::node_kind_t KIND = rs485_exp_pkg::KIND_RELAY,
    parameter int TIMEOUT_CYC = rs485_exp_pkg::LINK_TIMEOUT_CYC,
    parameter int BLINK_CYC = rs485_exp_pkg::BLINK_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    rs485_exp_if.node bus,
    input wire logic [rs485_exp_pkg::ADDR_W-1:0] addr_sw_i,
    input wire logic [rs485_exp_pkg::CH_OUT-1:0] din_i,
    input wire logic [rs485_exp_pkg::ADC_CH*rs485_exp_pkg::ADC_W-1:0] adc_i,
    output logic [rs485_exp_pkg::CH_OUT-1:0] relay_o,
    output logic [rs485_exp_pkg::DAC_CH*rs485_exp_pkg::DAC_W-1:0] dac_o,
    output logic lamp_o,
    output logic [1:0] state_o
);
    localparam int FW = rs485_exp_pkg::FRAME_W;
    localparam int BW = rs485_exp_pkg::BODY_W;
    localparam int PW = rs485_exp_pkg::PAY_W;
    localparam int AW = rs485_exp_pkg::ADDR_W;
    localparam int BC = rs485_exp_pkg::BIT_CYC;
    localparam int CW = rs485_exp_pkg::CNT_W;

    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_IDENT = 2'b01,
        ST_RUN = 2'b10
    } node_state_t;

    node_state_t state_reg;
    logic [AW-1:0] addr_reg;
    logic line_q;
    logic rx_busy;
    logic rx_done;
    logic [CW-1:0] rx_cnt;
    logic [rs485_exp_pkg::BITCNT_W-1:0] rx_bits;
    logic [FW-1:0] rx_sh;
    logic rx_ok;
    logic rx_ident;
    logic rx_data;
    logic tx_busy;
    logic tx_load;
    logic tx_wait;
    logic [CW-1:0] tx_cnt;
    logic [rs485_exp_pkg::BITCNT_W-1:0] tx_bits;
    logic [FW:0] tx_sh;
    logic [PW-1:0] reply_pay;
    logic [PW-1:0] cmd_pay_reg;
    logic [CW-1:0] tmo_cnt;
    logic [CW-1:0] blink_cnt;
    logic blink_reg;

    // switch address, sampled each cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            addr_reg <= 4'h0;
        end else begin
            addr_reg <= addr_sw_i;
        end
    end

    // frame receiver, blind while own transmitter runs
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            line_q <= 1'b1;
            rx_busy <= 1'b0;
            rx_done <= 1'b0;
            rx_cnt <= '0;
            rx_bits <= '0;
            rx_sh <= '0;
        end else begin
            line_q <= bus.line;
            rx_done <= 1'b0;
            if (!rx_busy) begin
                if (line_q && !bus.line && !tx_busy && !tx_wait) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= CW'(BC + BC / 2 - 1);
                    rx_bits <= '0;
                end
            end else if (rx_cnt != '0) begin
                rx_cnt <= rx_cnt - 1'b1;
            end else begin
                rx_sh <= {rx_sh[FW-2:0], bus.line};
                rx_cnt <= CW'(BC - 1);
                rx_bits <= rx_bits + 1'b1;
                if (rx_bits == rs485_exp_pkg::BITCNT_W'(FW - 1)) begin
                    rx_busy <= 1'b0;
                    rx_done <= 1'b1;
                end
            end
        end
    end

    // accept only crc-clean frames carrying our address
    assign rx_ok = rx_done
        && rx_sh[FW-1 -: AW] == addr_reg
        && rs485_exp_pkg::crc_calc(rx_sh[FW-1:rs485_exp_pkg::CRC_W])
            == rx_sh[rs485_exp_pkg::CRC_W-1:0];
    assign rx_ident = rx_ok
        && rx_sh[FW-AW-1 -: rs485_exp_pkg::FIELD_W] == rs485_exp_pkg::CMD_IDENT;
    assign rx_data = rx_ok && state_reg != ST_WAIT
        && rx_sh[FW-AW-1 -: rs485_exp_pkg::FIELD_W] == rs485_exp_pkg::CMD_DATA;

    // identification and link state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_WAIT;
            tmo_cnt <= '0;
        end else if (rx_ident) begin
            state_reg <= ST_IDENT;
            tmo_cnt <= '0;
        end else if (rx_data) begin
            state_reg <= ST_RUN;
            tmo_cnt <= '0;
        end else if (state_reg != ST_WAIT) begin
            if (tmo_cnt == CW'(TIMEOUT_CYC - 1)) begin
                state_reg <= ST_WAIT;
                tmo_cnt <= '0;
            end else begin
                tmo_cnt <= tmo_cnt + 1'b1;
            end
        end
    end

    // last commanded payload
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cmd_pay_reg <= '0;
        end else if (rx_data) begin
            cmd_pay_reg <= rx_sh[rs485_exp_pkg::CRC_W +: PW];
        end
    end

    // reply contents by kind
    always_comb begin
        reply_pay = '0;
        unique case (KIND)
            rs485_exp_pkg::KIND_INPUT: reply_pay[15:0] = {~din_i, din_i};
            rs485_exp_pkg::KIND_ANALOG: reply_pay = adc_i;
            rs485_exp_pkg::KIND_RELAY: reply_pay = '0;
            default: reply_pay = '0;
        endcase
    end

    assign tx_load = rx_ident || rx_data;

    // reply transmitter: turnaround gap, start bit, frame, stop bit
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_busy <= 1'b0;
            tx_wait <= 1'b0;
            tx_cnt <= '0;
            tx_bits <= '0;
            tx_sh <= '1;
        end else if (tx_load && !tx_busy && !tx_wait) begin
            tx_wait <= 1'b1;
            tx_cnt <= CW'(rs485_exp_pkg::TURN_CYC - 1);
            tx_bits <= '0;
            tx_sh <= {1'b0, addr_reg, KIND, reply_pay,
                rs485_exp_pkg::crc_calc({addr_reg, KIND, reply_pay})};
        end else if (tx_wait) begin
            tx_cnt <= tx_cnt == '0 ? CW'(BC - 1) : tx_cnt - 1'b1;
            tx_wait <= tx_cnt != '0;
            tx_busy <= tx_cnt == '0;
        end else if (tx_busy) begin
            if (tx_cnt != '0) begin
                tx_cnt <= tx_cnt - 1'b1;
            end else begin
                tx_cnt <= CW'(BC - 1);
                tx_sh <= {tx_sh[FW-1:0], 1'b1};
                tx_bits <= tx_bits + 1'b1;
                if (tx_bits == rs485_exp_pkg::BITCNT_W'(FW + 1)) begin
                    tx_busy <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bus.node_tx <= 1'b1;
            bus.node_oe <= 1'b0;
        end else begin
            bus.node_tx <= tx_sh[FW];
            bus.node_oe <= tx_busy;
        end
    end

    // blink base
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            blink_cnt <= '0;
            blink_reg <= 1'b0;
        end else if (blink_cnt == CW'(BLINK_CYC - 1)) begin
            blink_cnt <= '0;
            blink_reg <= ~blink_reg;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    // status lamp
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            lamp_o <= 1'b0;
            state_o <= ST_WAIT;
        end else begin
            state_o <= state_reg;
            unique case (state_reg)
                ST_WAIT: lamp_o <= blink_reg;
                ST_IDENT: lamp_o <= 1'b0;
                ST_RUN: lamp_o <= 1'b1;
                default: lamp_o <= blink_reg;
            endcase
        end
    end

    // outputs, forced to error value unless running
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || state_reg != ST_RUN || KIND != rs485_exp_pkg::KIND_RELAY) begin
            relay_o <= '0;
        end else begin
            relay_o <= cmd_pay_reg[7:0] ^ cmd_pay_reg[rs485_exp_pkg::INV_POS +: 8];
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < rs485_exp_pkg::DAC_CH; ch++) begin : g_dac
            always_ff @(posedge sys_clk_i) begin
                if (rst_i || state_reg != ST_RUN
                    || KIND != rs485_exp_pkg::KIND_ANALOG) begin
                    dac_o[ch*rs485_exp_pkg::DAC_W +: rs485_exp_pkg::DAC_W] <= '0;
                end else if (!cmd_pay_reg[rs485_exp_pkg::DAC_EN_POS + ch]) begin
                    dac_o[ch*rs485_exp_pkg::DAC_W +: rs485_exp_pkg::DAC_W] <= '0;
                end else begin
                    dac_o[ch*rs485_exp_pkg::DAC_W +: rs485_exp_pkg::DAC_W] <=
                        cmd_pay_reg[ch*rs485_exp_pkg::DAC_W +: rs485_exp_pkg::DAC_W];
                end
            end
        end
    endgenerate
endmodule

// ### hw/rs485_exp_host.sv
// rs485 bus host: discovery, periodic polling, drop handling
`timescale 1ns/1ns
module rs485_exp_host #(
    parameter int SLOT_CYC = rs485_exp_pkg::SLOT_CYC,
    parameter int MISS_LIMIT = rs485_exp_pkg::MISS_LIMIT,
    parameter int BLINK_CYC = rs485_exp_pkg::BLINK_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    rs485_exp_if.host bus,
    input wire logic rescan_i,
    input wire logic [rs485_exp_pkg::NODES*rs485_exp_pkg::PAY_W-1:0] out_data_i,
    output logic [rs485_exp_pkg::NODES*rs485_exp_pkg::PAY_W-1:0] in_data_o,
    output logic [rs485_exp_pkg::NODES*rs485_exp_pkg::FIELD_W-1:0] node_kind_o,
    output logic [rs485_exp_pkg::NODES-1:0] present_o,
    output logic dropped_o,
    output logic lamp_o
);
    localparam int FW = rs485_exp_pkg::FRAME_W;
    localparam int PW = rs485_exp_pkg::PAY_W;
    localparam int AW = rs485_exp_pkg::ADDR_W;
    localparam int KW = rs485_exp_pkg::FIELD_W;
    localparam int BC = rs485_exp_pkg::BIT_CYC;
    localparam int CW = rs485_exp_pkg::CNT_W;

    typedef enum logic [0:0] {
        H_INIT = 1'b0,
        H_RUN = 1'b1
    } host_state_t;

    host_state_t state_reg;
    logic [AW-1:0] slot_addr;
    logic [CW-1:0] slot_cnt;
    logic got_reg;
    logic [7:0] miss [rs485_exp_pkg::NODES];
    logic line_q;
    logic rx_busy;
    logic [CW-1:0] rx_cnt;
    logic [rs485_exp_pkg::BITCNT_W-1:0] rx_bits;
    logic [FW-1:0] rx_sh;
    logic rx_done;
    logic rx_ok;
    logic tx_busy;
    logic [CW-1:0] tx_cnt;
    logic [rs485_exp_pkg::BITCNT_W-1:0] tx_bits;
    logic [FW:0] tx_sh;
    logic [KW-1:0] cmd;
    logic [PW-1:0] pay;
    logic slot_end;
    logic [CW-1:0] blink_cnt;
    logic blink_reg;

    assign slot_end = slot_cnt == CW'(SLOT_CYC - 1);
    assign cmd = state_reg == H_INIT ? rs485_exp_pkg::CMD_IDENT : rs485_exp_pkg::CMD_DATA;
    assign pay = state_reg == H_INIT ? '0 : out_data_i[slot_addr*PW +: PW];

    // reply receiver
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            line_q <= 1'b1;
            rx_busy <= 1'b0;
            rx_done <= 1'b0;
            rx_cnt <= '0;
            rx_bits <= '0;
            rx_sh <= '0;
        end else begin
            line_q <= bus.line;
            rx_done <= 1'b0;
            if (!rx_busy) begin
                if (line_q && !bus.line && !tx_busy) begin
                    rx_busy <= 1'b1;
                    rx_cnt <= CW'(BC + BC / 2 - 1);
                    rx_bits <= '0;
                end
            end else if (rx_cnt != '0) begin
                rx_cnt <= rx_cnt - 1'b1;
            end else begin
                rx_sh <= {rx_sh[FW-2:0], bus.line};
                rx_cnt <= CW'(BC - 1);
                rx_bits <= rx_bits + 1'b1;
                if (rx_bits == rs485_exp_pkg::BITCNT_W'(FW - 1)) begin
                    rx_busy <= 1'b0;
                    rx_done <= 1'b1;
                end
            end
        end
    end

    assign rx_ok = rx_done && rx_sh[FW-1 -: AW] == slot_addr
        && rs485_exp_pkg::crc_calc(rx_sh[FW-1:rs485_exp_pkg::CRC_W])
            == rx_sh[rs485_exp_pkg::CRC_W-1:0];

    // request transmitter, one frame at slot start
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_busy <= 1'b0;
            tx_cnt <= '0;
            tx_bits <= '0;
            tx_sh <= '1;
        end else if (slot_cnt == '0 && (state_reg == H_INIT || present_o[slot_addr])) begin
            tx_busy <= 1'b1;
            tx_cnt <= CW'(BC - 1);
            tx_bits <= '0;
            tx_sh <= {1'b0, slot_addr, cmd, pay,
                rs485_exp_pkg::crc_calc({slot_addr, cmd, pay})};
        end else if (tx_busy) begin
            if (tx_cnt != '0) begin
                tx_cnt <= tx_cnt - 1'b1;
            end else begin
                tx_cnt <= CW'(BC - 1);
                tx_sh <= {tx_sh[FW-1:0], 1'b1};
                tx_bits <= tx_bits + 1'b1;
                if (tx_bits == rs485_exp_pkg::BITCNT_W'(FW + 1)) begin
                    tx_busy <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bus.host_tx <= 1'b1;
            bus.host_oe <= 1'b0;
        end else begin
            bus.host_tx <= tx_sh[FW];
            bus.host_oe <= tx_busy;
        end
    end

    // slot sequencing over addresses 0 to 15
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || rescan_i) begin
            state_reg <= H_INIT;
            slot_addr <= 4'h0;
            slot_cnt <= '0;
            got_reg <= 1'b0;
        end else begin
            got_reg <= (got_reg || rx_ok) && !slot_end;
            slot_cnt <= slot_end ? '0 : slot_cnt + 1'b1;
            if (slot_end) begin
                slot_addr <= slot_addr + 1'b1;
                if (slot_addr == 4'hF) begin
                    state_reg <= H_RUN;
                end
            end
        end
    end

    // node table, miss counting and drop
    genvar n;
    generate
        for (n = 0; n < rs485_exp_pkg::NODES; n++) begin : g_node
            always_ff @(posedge sys_clk_i) begin
                if (rst_i || rescan_i) begin
                    present_o[n] <= 1'b0;
                    miss[n] <= 8'h00;
                    node_kind_o[n*KW +: KW] <= '0;
                    in_data_o[n*PW +: PW] <= '0;
                end else if (slot_addr == AW'(n)) begin
                    if (rx_ok) begin
                        node_kind_o[n*KW +: KW] <= rx_sh[FW-AW-1 -: KW];
                        in_data_o[n*PW +: PW] <= rx_sh[rs485_exp_pkg::CRC_W +: PW];
                    end
                    if (slot_end && state_reg == H_INIT) begin
                        present_o[n] <= got_reg || rx_ok;
                        miss[n] <= 8'h00;
                    end else if (slot_end && present_o[n]) begin
                        if (got_reg || rx_ok) begin
                            miss[n] <= 8'h00;
                        end else if (miss[n] == 8'(MISS_LIMIT - 1)) begin
                            present_o[n] <= 1'b0;
                        end else begin
                            miss[n] <= miss[n] + 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // any drop since last scan
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || rescan_i) begin
            dropped_o <= 1'b0;
        end else if (slot_end && state_reg == H_RUN && present_o[slot_addr]
            && !(got_reg || rx_ok) && miss[slot_addr] == 8'(MISS_LIMIT - 1)) begin
            dropped_o <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            blink_cnt <= '0;
            blink_reg <= 1'b0;
        end else if (blink_cnt == CW'(BLINK_CYC - 1)) begin
            blink_cnt <= '0;
            blink_reg <= ~blink_reg;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    // bus lamp
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            lamp_o <= 1'b0;
        end else if (state_reg == H_INIT) begin
            lamp_o <= blink_reg;
        end else if (dropped_o) begin
            lamp_o <= 1'b0;
        end else begin
            lamp_o <= 1'b1;
        end
    end
endmodule

// ### tb/rs485_exp_chk.sv
// line checker for the rs485 expander bus
`timescale 1ns/1ns
module rs485_exp_chk #(
    parameter int SLOT_CYC = 1500
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic host_tx,
    input wire logic host_oe,
    input wire logic node_tx,
    input wire logic node_oe,
    input wire logic line
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    int hcnt;
    int ncnt;
    int scnt;
    logic seen;
    // cycles each end has been driving
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            hcnt <= 0;
            ncnt <= 0;
        end else begin
            hcnt <= host_oe ? hcnt + 1 : 0;
            ncnt <= node_oe ? ncnt + 1 : 0;
        end
    end
    // cycles since last request start
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            scnt <= 0;
            seen <= 1'b0;
        end else if (host_oe && hcnt == 0) begin
            scnt <= 1;
            seen <= 1'b1;
        end else begin
            scnt <= scnt + 1;
        end
    end
    a_start_bit_low: assert property (host_oe && hcnt == 0 |-> (host_oe && !host_tx) [*8])
        else $error("host start bit not low");
    a_host_frame_len: assert property ($fell(host_oe) |-> hcnt == 500)
        else $error("host frame length wrong");
    a_node_frame_len: assert property ($fell(node_oe) |-> ncnt == 500)
        else $error("node frame length wrong");
    a_stop_bit_high: assert property ($fell(host_oe) |-> $past(host_tx))
        else $error("host stop bit not high");
    a_host_idle_high: assert property (!host_oe |-> host_tx)
        else $error("host tx not idle high");
    a_bit_grid: assert property ($changed(host_tx) && host_oe |->
        hcnt % rs485_exp_pkg::BIT_CYC == 0)
        else $error("host bit edge off grid");
    a_reply_window: assert property (node_oe && ncnt == 0 |-> $past(host_oe, 9))
        else $error("node spoke without request");
    a_no_contention: assert property (!(host_oe && node_oe))
        else $error("both ends drive the line");
    a_node_start_low: assert property (node_oe && ncnt == 0 |-> (node_oe && !node_tx) [*8])
        else $error("node start bit not low");
    a_slot_grid: assert property (host_oe && hcnt == 0 && seen |-> scnt % SLOT_CYC == 0)
        else $error("request off slot grid");
endmodule

// ### tb/rs485_io_expander_bus_tb_top.sv
// bench: host with three nodes, one node on a bench-driven line
`timescale 1ns/1ns
module rs485_io_expander_bus_tb_top;
    localparam int SLOT = 1200;
    localparam rs485_exp_pkg::node_kind_t KINDS [4] = '{rs485_exp_pkg::KIND_RELAY,
        rs485_exp_pkg::KIND_INPUT, rs485_exp_pkg::KIND_ANALOG, rs485_exp_pkg::KIND_RELAY};
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    int cyc = 0;
    int fail_count = 0;
    int compares = 0;
    logic [511:0] out_data = '0;
    logic [511:0] in_data;
    logic [63:0] kinds;
    logic [15:0] present;
    logic dropped;
    logic [7:0] din = 8'h3C;
    logic [31:0] adc = 32'h89AB_CDEF;
    logic [3:0] addr [4] = '{4'h2, 4'h5, 4'h9, 4'h3};
    logic [7:0] rel [4];
    logic [23:0] dac [4];
    logic lamps [5];
    logic [1:0] st [4];
    logic xtx = 1'b1;
    logic xoe = 1'b0;
    rs485_exp_if bus_if();
    rs485_exp_if n_if[4]();

    always #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) cyc <= rst_i ? 0 : cyc + 1;

    assign bus_if.node_oe = n_if[0].node_oe | n_if[1].node_oe | n_if[2].node_oe;
    assign bus_if.node_tx = (n_if[0].node_tx | !n_if[0].node_oe)
        & (n_if[1].node_tx | !n_if[1].node_oe) & (n_if[2].node_tx | !n_if[2].node_oe);
    assign n_if[3].host_tx = xtx;
    assign n_if[3].host_oe = xoe;

    rs485_exp_host #(.SLOT_CYC(SLOT), .MISS_LIMIT(1), .BLINK_CYC(50)) i_rs485_exp_host (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus_if.host), .rescan_i(1'b0),
        .out_data_i(out_data), .in_data_o(in_data), .node_kind_o(kinds),
        .present_o(present), .dropped_o(dropped), .lamp_o(lamps[4]));

    for (genvar k = 0; k < 4; k++) begin : g_node
        rs485_exp_node #(.KIND(KINDS[k]), .TIMEOUT_CYC(25000), .BLINK_CYC(50)) i_rs485_exp_node (
            .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(n_if[k].node), .addr_sw_i(addr[k]),
            .din_i(din), .adc_i(adc), .relay_o(rel[k]), .dac_o(dac[k]), .lamp_o(lamps[k]),
            .state_o(st[k]));
        if (k < 3) begin : g_join
            assign n_if[k].host_oe = 1'b1;
            assign n_if[k].host_tx = bus_if.line;
        end
    end

    rs485_exp_chk #(.SLOT_CYC(SLOT)) i_rs485_exp_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .host_tx(bus_if.host_tx), .host_oe(bus_if.host_oe), .node_tx(bus_if.node_tx),
        .node_oe(bus_if.node_oe), .line(bus_if.line));

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_to(input int c);
        while (cyc < c) @(posedge sys_clk_i);
    endtask

    task automatic check_blink(input int k, input logic exp);
        int n;
        logic prev;
        n = 0;
        prev = lamps[k];
        repeat (150) begin
            @(posedge sys_clk_i);
            if (lamps[k] !== prev) n++;
            prev = lamps[k];
        end
        check_val(n > 1, exp, "lamp blink");
    endtask

    task automatic send(input logic [3:0] a, input logic [3:0] f, input logic [31:0] p,
            input logic bad);
        logic [47:0] fr;
        fr = {a, f, p, rs485_exp_pkg::crc_calc({a, f, p}) ^ {7'h00, bad}};
        @(posedge sys_clk_i);
        xoe <= 1'b1;
        xtx <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        for (int i = 47; i >= 0; i--) begin
            xtx <= fr[i];
            repeat (10) @(posedge sys_clk_i);
        end
        xtx <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        xoe <= 1'b0;
    endtask

    task automatic reply(output logic got, output logic [47:0] fr);
        got = 1'b0;
        fr = '0;
        for (int i = 0; i < 40 && !got; i++) begin
            @(posedge sys_clk_i);
            got = n_if[3].node_oe;
        end
        if (got) begin
            repeat (15) @(posedge sys_clk_i);
            for (int i = 47; i >= 0; i--) begin
                fr[i] = n_if[3].line;
                repeat (10) @(posedge sys_clk_i);
            end
            repeat (20) @(posedge sys_clk_i);
        end
    endtask

    task automatic t_early();
        check_blink(0, 1'b1);
        check_blink(4, 1'b1);
        check_val(st[0], 2'h0, "state before ident");
        wait_to(3300);
        check_val(st[0], 2'h1, "state in ident");
        check_val(lamps[0], 1'b0, "lamp in ident");
        check_blink(0, 1'b0);
        $display("t_early done");
    endtask

    task automatic t_rogue();
        logic got;
        logic [47:0] fr;
        send(4'h3, rs485_exp_pkg::CMD_IDENT, 32'h0, 1'b1);
        reply(got, fr);
        check_val(got, 1'b0, "bad crc answered");
        send(4'h4, rs485_exp_pkg::CMD_IDENT, 32'h0, 1'b0);
        reply(got, fr);
        check_val(got, 1'b0, "other address answered");
        send(4'h3, rs485_exp_pkg::CMD_IDENT, 32'h0, 1'b0);
        reply(got, fr);
        check_val(got, 1'b1, "ident reply");
        check_val(fr[47:44], 4'h3, "reply address");
        check_val(fr[43:40], rs485_exp_pkg::KIND_RELAY, "reply kind");
        check_val(lamps[3], 1'b0, "lamp in ident");
        send(4'h3, rs485_exp_pkg::CMD_DATA, 32'h0000_F033, 1'b0);
        reply(got, fr);
        check_val(rel[3], 8'hC3, "relay inverted");
        check_val(st[3], 2'h2, "state run");
        check_val(lamps[3], 1'b1, "lamp run");
        $display("t_rogue done");
    endtask

    task automatic t_found();
        wait_to(19500);
        check_val(present, 16'h0224, "present nodes");
        for (int k = 0; k < 3; k++) begin
            check_val(kinds[addr[k]*4+:4], KINDS[k], "node kind");
        end
        $display("t_found done");
    endtask

    task automatic t_run();
        wait_to(39500);
        check_val(rel[0], 8'hAA, "relay levels");
        check_val(in_data[5*32+:16], {~din, din}, "inputs and complement");
        check_val(in_data[9*32+:32], adc, "adc values");
        check_val(dac[2], 24'h03_F03F, "dac with enables");
        for (int k = 0; k < 3; k++) begin
            check_val(lamps[k], 1'b1, "node lamp run");
        end
        check_val(lamps[4], 1'b1, "host lamp run");
        $display("t_run done");
    endtask

    task automatic t_drop();
        @(posedge sys_clk_i);
        addr[2] <= 4'hA;
        for (int i = 0; i < 25000 && dropped !== 1'b1; i++) @(posedge sys_clk_i);
        check_val(dropped, 1'b1, "drop flag");
        check_val(present, 16'h0024, "present after drop");
        check_blink(4, 1'b0);
        check_val(lamps[4], 1'b0, "host lamp dark");
        for (int i = 0; i < 30000 && st[2] !== 2'h0; i++) @(posedge sys_clk_i);
        repeat (2) @(posedge sys_clk_i);
        check_val(dac[2], 24'h0, "dac safe");
        check_blink(2, 1'b1);
        check_val(rel[0], 8'hAA, "relay kept");
        $display("t_drop done");
    endtask

    task automatic results();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_i);
        out_data[2*32+:32] <= 32'h0000_0FA5;
        out_data[9*32+:32] <= 32'h05FF_FFFF;
        rst_i <= 1'b0;
        t_early();
        t_rogue();
        t_found();
        t_run();
        t_drop();
        results();
    end

    initial begin
        #9_000_000;
        fail_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        results();
    end
endmodule
